// File: design/byte_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] level, next_level;
  logic do_wr, do_rd;

  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    next_level = level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_level = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: design/seq_pkg.sv
// Shared constants and types for the host command sequencer
package seq_pkg;
  localparam int CMD_BYTES = 6;
  localparam int CMD_CNT_W = 3;
  localparam logic [7:0] SENSE_OPCODE = 8'h03;
  localparam int CTRL_NORETRY_BIT = 7;
  localparam logic [2:0] RETRY_TRIES = 3'h4;
  localparam int UNIT_HI = 6;
  localparam int UNIT_LO = 5;
  localparam int ADDR_TOP_W = 5;
  localparam int SECTOR_SMALL = 256;
  localparam int SECTOR_LARGE = 512;
  localparam int RESP_DIR_BIT = 7;
  localparam int RESP_ERR_BIT = 6;
  localparam int RESP_CD_BIT = 5;
  localparam int RESP_MSG_BIT = 4;
  localparam logic [3:0] CTRL_ADDR_DEFAULT = 4'h0;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;

  typedef struct packed {
    logic [7:0] opcode;
    logic zero7;
    logic [1:0] unit;
    logic [ADDR_TOP_W-1:0] addr_hi;
    logic [7:0] addr_mid;
    logic [7:0] addr_lo;
    logic [7:0] count;
    logic [7:0] control;
  } cmd_block_t;

  typedef struct packed {
    logic direction;
    logic cmd_data;
    logic message;
    logic byte_request;
    logic busy;
  } phase_flags_t;

  typedef enum logic [1:0] {
    ERR_NONE,
    ERR_RECOVERABLE,
    ERR_FATAL
  } err_kind_t;
endpackage

// File: design/storage_ctrl_host_command_sequencer.sv
// Host-side command sequencer: select, command, data, status and message phases
// How it works
// - After reset or command end, sit idle awaiting select.
// - Command fetch: command/data high, direction low.
// - Interrupt host once command fetch flags are set.
// - After a command byte, raise byte-request for the next.
// - Fetch ends after six bytes with byte-request dropped.
// - Data phase: command/data low, direction per transfer way.
// - Interrupt when ready for data; leave when all bytes moved, or earlier on an error.
// - Commands without data skip straight to status and message.
// - Status: byte on bus, command/data and direction high, message low, interrupt.
// - Message: flags high, byte-request high, interrupt.
// - After message read, phase flags, byte-request and busy drop to zero; ready again.
// - Nonrecoverable error abandons command, jumps to status.
// - Channel error ends command normally, sectors may have moved.
// - Keep only latest error; fatal overwrites recoverable.
// - Sectors of 256 or 512 bytes move whole or not at all.
// - Sense command 03h returns failed sector's logical address; opcode 03h is not decoded here, failed_lba is just an output port.
// - Six-byte command block: opcode, unit/address, address, count, control.
// - Control bit 7 disables retry; else four tries, success correctable.
// - State decodes from direction, command/data, message flags.
// - Read/write while byte-request low flags invalid request and interrupts.
// - Acknowledge returns address, state flags and error bit.
`timescale 1ns/1ps
`default_nettype none
module storage_ctrl_host_command_sequencer
  import seq_pkg::*;
#(
  parameter logic [3:0] CTRL_ADDR = CTRL_ADDR_DEFAULT,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host bus commands (pins)
  input wire logic host_select,
  input wire logic host_write,
  input wire logic host_read,
  input wire logic host_int_ack,
  input wire logic host_parity_bad,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_irq,
  // Phase flags
  output logic direction,
  output logic cmd_data,
  output logic message_phase_flag,
  output logic byte_request,
  output logic busy,
  output logic invalid_request_flag,
  output logic host_bus_parity_error_flag,
  // Execution engine side
  output var cmd_block_t cmd_block,
  output logic cmd_valid,
  input wire logic exec_has_data,
  input wire logic exec_to_host,
  input wire logic [9:0] exec_sector_len,
  input wire logic [7:0] exec_sector_count,
  input wire logic exec_attempt_fail,
  input wire logic exec_fatal_error,
  input wire logic exec_channel_error,
  input wire logic [7:0] exec_err_code,
  input wire logic exec_unit_wp,
  // Data to host stream
  input wire logic to_host_valid,
  output logic to_host_ready,
  input wire logic [7:0] to_host_data,
  // Data from host stream
  output logic from_host_valid,
  input wire logic from_host_ready,
  output logic [7:0] from_host_data,
  // Status out
  output logic retry_correctable,
  output logic [23:0] failed_lba
);
  typedef enum {S_IDLE, S_FETCH, S_EXEC, S_DATA, S_STATUS, S_MESSAGE} state_t;

  // Pin synchronisers
  logic [5:0] sync1, sync2, sync_prev;
  logic sel_p, wr_p, rd_p, ack_p, par_p;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync_prev <= '0;
    end else begin
      sync1 <= {host_select, host_write, host_read, host_int_ack, host_parity_bad, 1'b0};
      sync2 <= sync1;
      sync_prev <= sync2;
    end
  end
  assign sel_p = sync2[5] & ~sync_prev[5];
  assign wr_p = sync2[4] & ~sync_prev[4];
  assign rd_p = sync2[3] & ~sync_prev[3];
  assign ack_p = sync2[2] & ~sync_prev[2];
  assign par_p = sync2[1] & ~sync_prev[1];
  logic [7:0] wdata_s1, wdata_s2;
  always_ff @(posedge mclk) begin
    wdata_s1 <= host_wdata;
    wdata_s2 <= wdata_s1;
  end

  // FIFO in the controller-to-host path; reads drain it
  logic fifo_out_valid, fifo_out_ready, fifo_in_ready;
  logic [7:0] fifo_out_data;
  logic fifo_flush;
  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .flush(fifo_flush),
    .in_valid(to_host_valid & to_host_ready),
    .in_ready(fifo_in_ready),
    .in_data(to_host_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  state_t state, next_state;
  logic [CMD_CNT_W-1:0] byte_cnt, next_byte_cnt;
  logic [9:0] sec_byte, next_sec_byte;
  logic [7:0] sec_left, next_sec_left;
  logic [2:0] tries, next_tries;
  logic [7:0] err_code, next_err_code;
  logic err_seen, next_err_seen;
  logic [23:0] next_failed_lba, cur_lba, next_cur_lba;
  cmd_block_t next_cmd_block;
  logic next_cmd_valid, next_retry_correctable;
  logic next_dir, next_cd, next_msg, next_req, next_busy;
  logic next_inv, next_par, next_irq;
  logic [7:0] next_rdata;
  logic next_to_host_ready, next_fh_valid;
  logic [7:0] next_fh_data;
  logic bad_access, fatal, data_done;

  assign bad_access = (wr_p | rd_p) & ~byte_request;
  assign fatal = exec_fatal_error | par_p;
  assign fifo_out_ready = (state == S_DATA) && direction && rd_p && byte_request;
  assign fifo_flush = (state == S_IDLE);
  assign data_done = (sec_left == 8'h0) && !from_host_valid;

  always_comb begin
    next_state = state;
    next_byte_cnt = byte_cnt;
    next_sec_byte = sec_byte;
    next_sec_left = sec_left;
    next_tries = tries;
    next_err_code = err_code;
    next_err_seen = err_seen;
    next_failed_lba = failed_lba;
    next_cur_lba = cur_lba;
    next_cmd_block = cmd_block;
    next_cmd_valid = 1'b0;
    next_retry_correctable = retry_correctable;
    next_dir = direction;
    next_cd = cmd_data;
    next_msg = message_phase_flag;
    next_req = byte_request;
    next_busy = busy;
    next_inv = invalid_request_flag;
    next_par = host_bus_parity_error_flag;
    next_irq = host_irq;
    next_rdata = host_rdata;
    // Ready every other cycle at most, so the registered flag can never overfill the buffer
    next_to_host_ready = fifo_in_ready && (state == S_DATA) && direction && !to_host_ready;
    next_fh_valid = from_host_valid & ~from_host_ready;
    next_fh_data = from_host_data;
    if (ack_p) begin
      next_irq = 1'b0;
      next_rdata = {direction, invalid_request_flag | host_bus_parity_error_flag,
                    cmd_data, message_phase_flag, CTRL_ADDR};
      next_inv = 1'b0;
      next_par = 1'b0;
    end
    if (bad_access) begin
      next_inv = 1'b1;
      next_irq = 1'b1;
    end
    if (par_p) begin
      next_par = 1'b1;
      next_irq = 1'b1;
    end

    case (state)
      S_IDLE: begin
        next_dir = 1'b0;
        next_cd = 1'b0;
        next_msg = 1'b0;
        next_req = 1'b0;
        next_busy = 1'b0;
        if (sel_p) begin
          next_busy = 1'b1;
          next_cd = 1'b1;
          next_dir = 1'b0;
          next_req = 1'b1;
          next_irq = 1'b1;
          next_byte_cnt = '0;
          next_err_code = 8'h00;
          next_err_seen = 1'b0;
          next_retry_correctable = 1'b0;
          next_state = S_FETCH;
        end
      end
      S_FETCH: begin
        if (par_p) begin
          next_state = S_STATUS;
        end else if (wr_p && byte_request) begin
          // Bytes arrive MSB first into the packed block
          next_cmd_block = {cmd_block[39:0], wdata_s2};
          if (byte_cnt == CMD_CNT_W'(CMD_BYTES - 1)) begin
            next_req = 1'b0;
            next_cmd_valid = 1'b1;
            next_tries = '0;
            next_state = S_EXEC;
          end else begin
            next_req = 1'b1;
            next_byte_cnt = byte_cnt + 1'b1;
          end
        end
      end
      S_EXEC: begin
        next_cur_lba = {3'h0, cmd_block.addr_hi, cmd_block.addr_mid, cmd_block.addr_lo};
        if (fatal || exec_channel_error || !exec_has_data) begin
          next_state = S_STATUS;
        end else begin
          next_cd = 1'b0;
          next_dir = exec_to_host;
          next_irq = 1'b1;
          next_sec_byte = '0;
          next_sec_left = exec_sector_count;
          next_state = S_DATA;
        end
      end
      S_DATA: begin
        if (direction) begin
          next_req = fifo_out_valid;
          if (fifo_out_ready) begin
            next_rdata = fifo_out_data;
          end
        end else begin
          next_req = ~from_host_valid && (sec_left != 8'h0);
          if (wr_p && byte_request) begin
            next_fh_valid = 1'b1;
            next_fh_data = wdata_s2;
          end
        end
        if ((fifo_out_ready || (wr_p && byte_request && !direction))) begin
          // Sector granularity: only count whole sectors as moved
          if (sec_byte == exec_sector_len - 10'h1) begin
            next_sec_byte = '0;
            next_sec_left = sec_left - 8'h1;
            next_cur_lba = cur_lba + 24'h1;
          end else begin
            next_sec_byte = sec_byte + 10'h1;
          end
        end
        if (data_done) begin
          next_state = S_STATUS;
        end
        if (exec_attempt_fail) begin
          if (!cmd_block.control[CTRL_NORETRY_BIT] && tries < RETRY_TRIES - 3'h1) begin
            next_tries = tries + 3'h1;
            next_retry_correctable = 1'b1;
          end else begin
            next_state = S_STATUS;
          end
        end
        if (fatal || exec_channel_error) begin
          next_state = S_STATUS;
        end
      end
      S_STATUS: begin
        next_cd = 1'b1;
        next_dir = 1'b1;
        next_msg = 1'b0;
        next_req = 1'b1;
        if (rd_p && byte_request) begin
          next_msg = 1'b1;
          next_irq = 1'b1;
          next_rdata = err_code;
          next_state = S_MESSAGE;
        end
      end
      S_MESSAGE: begin
        if (rd_p && byte_request) begin
          next_state = S_IDLE;
          next_req = 1'b0;
          next_busy = 1'b0;
          next_cd = 1'b0;
          next_dir = 1'b0;
          next_msg = 1'b0;
          next_rdata = 8'h00;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // Latest error wins; fatal overwrites recoverable
    if (state != S_IDLE && (exec_attempt_fail || fatal || exec_channel_error)) begin
      next_err_seen = 1'b1;
      next_err_code = {1'b1, exec_err_code[6:0]};
      next_failed_lba = cur_lba;
    end
    if (state != S_STATUS && next_state == S_STATUS) begin
      next_irq = 1'b1;
      next_req = 1'b0;
      next_fh_valid = 1'b0;
      next_rdata = {1'b0, cmd_block.unit, 1'b0, exec_unit_wp, 1'b0, next_err_seen, 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
      byte_cnt <= '0;
      sec_byte <= '0;
      sec_left <= '0;
      tries <= '0;
      err_code <= '0;
      err_seen <= 1'b0;
      failed_lba <= '0;
      cur_lba <= '0;
      cmd_block <= '0;
      cmd_valid <= 1'b0;
      retry_correctable <= 1'b0;
      direction <= 1'b0;
      cmd_data <= 1'b0;
      message_phase_flag <= 1'b0;
      byte_request <= 1'b0;
      busy <= 1'b0;
      invalid_request_flag <= 1'b0;
      host_bus_parity_error_flag <= 1'b0;
      host_irq <= 1'b0;
      host_rdata <= '0;
      to_host_ready <= 1'b0;
      from_host_valid <= 1'b0;
      from_host_data <= '0;
    end else begin
      state <= next_state;
      byte_cnt <= next_byte_cnt;
      sec_byte <= next_sec_byte;
      sec_left <= next_sec_left;
      tries <= next_tries;
      err_code <= next_err_code;
      err_seen <= next_err_seen;
      failed_lba <= next_failed_lba;
      cur_lba <= next_cur_lba;
      cmd_block <= next_cmd_block;
      cmd_valid <= next_cmd_valid;
      retry_correctable <= next_retry_correctable;
      direction <= next_dir;
      cmd_data <= next_cd;
      message_phase_flag <= next_msg;
      byte_request <= next_req;
      busy <= next_busy;
      invalid_request_flag <= next_inv;
      host_bus_parity_error_flag <= next_par;
      host_irq <= next_irq;
      host_rdata <= next_rdata;
      to_host_ready <= next_to_host_ready;
      from_host_valid <= next_fh_valid;
      from_host_data <= next_fh_data;
    end
  end
endmodule
`default_nettype wire

// File: testbench/host_model.sv
// Host processor model driving the bus command pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic mclk,
  // Bus pins
  output logic host_select,
  output logic host_write,
  output logic host_read,
  output logic host_int_ack,
  output logic host_parity_bad,
  output logic [7:0] host_wdata
);
  initial begin
    {host_select, host_write, host_read, host_int_ack, host_parity_bad} = '0;
    host_wdata = 8'h5a;
  end
  // Raise one bus command pin; data is set together and held while it stands
  task automatic start(input int kind, input logic [7:0] d);
    @(posedge mclk);
    host_wdata <= d;
    case (kind)
      0: host_select <= 1'b1;
      1: host_write <= 1'b1;
      2: host_read <= 1'b1;
      default: host_int_ack <= 1'b1;
    endcase
  endtask
  // Released bus shows the inverse, never the stale byte
  task automatic stop;
    @(posedge mclk);
    {host_select, host_write, host_read, host_int_ack} <= '0;
    host_wdata <= ~host_wdata;
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// File: testbench/seq_checker.sv
// Port-level assertions for the host command sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host pins
  input wire logic host_select,
  input wire logic host_write,
  input wire logic host_irq,
  // Phase flags
  input wire logic direction,
  input wire logic cmd_data,
  input wire logic message_phase_flag,
  input wire logic byte_request,
  input wire logic busy,
  input wire logic invalid_request_flag,
  // Streams
  input wire logic cmd_valid,
  input wire logic to_host_ready,
  input wire logic from_host_valid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence fetch_entry;
    busy && cmd_data && !direction && host_irq;
  endsequence
  // Pin edge is taken only after the synchroniser, so sample the low level across it
  sequence refused_write;
    $rose(host_write) ##0 !byte_request [*4];
  endsequence

  a_fetch_entry: assert property (!busy && $rose(host_select) |-> ##[2:6] fetch_entry)
    else $error("select did not open command fetch");
  a_fetch_decode: assert property (cmd_data && !direction |-> !message_phase_flag)
    else $error("command fetch shows message flag");
  a_fetch_end: assert property (cmd_valid |-> ##[0:1] !byte_request)
    else $error("byte request still high after sixth byte");
  a_message_decode: assert property (message_phase_flag |-> cmd_data && direction && busy)
    else $error("message flag outside message phase");
  a_to_host_phase: assert property (to_host_ready |-> busy && !cmd_data && direction)
    else $error("output stream open outside input data phase");
  a_from_host_phase: assert property (from_host_valid |-> busy && !cmd_data && !direction)
    else $error("host data outside output data phase");
  a_refused_req: assert property (refused_write |-> ##[0:3] invalid_request_flag && host_irq)
    else $error("write without request not flagged");
  a_idle_quiet: assert property (!busy |-> !cmd_data && !direction && !message_phase_flag)
    else $error("phase flags up while idle");
  a_release_all: assert property ($fell(busy) |-> !byte_request)
    else $error("byte request left high at command end");
  a_status_entry: assert property ($rose(cmd_data && direction) |-> ##[0:1] host_irq && !message_phase_flag)
    else $error("status phase without interrupt");
endmodule
`default_nettype wire

// File: testbench/test_storage_ctrl_host_command_sequencer.sv
// Self-checking bench for the host command sequencer
`timescale 1ns/1ps
`default_nettype none
module test_storage_ctrl_host_command_sequencer
  import seq_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wire logic host_select, host_write, host_read, host_int_ack, host_parity_bad;
  wire logic [7:0] host_wdata;
  logic [7:0] host_rdata;
  logic host_irq, direction, cmd_data, message_phase_flag, byte_request, busy;
  logic invalid_request_flag, host_bus_parity_error_flag, cmd_valid;
  cmd_block_t cmd_block;
  logic exec_has_data = 1'b0, exec_to_host = 1'b0, exec_fatal_error = 1'b0;
  logic [9:0] exec_sector_len = 10'h100;
  logic [7:0] exec_sector_count = 8'h01;
  logic [7:0] exec_err_code = 8'h00;
  logic to_host_valid = 1'b0, from_host_ready = 1'b0, to_host_ready, from_host_valid;
  logic [7:0] to_host_data = 8'h00, from_host_data;
  logic retry_correctable;
  logic [23:0] failed_lba;
  int failures = 0, checks = 0, seed = 73526, left = 0;
  logic [7:0] q[$], w[$];
  wire [5:0] fl = {busy, direction, cmd_data, message_phase_flag, byte_request, host_irq};

  always #2 mclk = ~mclk;

  host_model hm (.mclk, .host_select, .host_write, .host_read, .host_int_ack,
    .host_parity_bad, .host_wdata);
  storage_ctrl_host_command_sequencer uut (.mclk, .rst, .host_select, .host_write,
    .host_read, .host_int_ack, .host_parity_bad, .host_wdata, .host_rdata, .host_irq,
    .direction, .cmd_data, .message_phase_flag, .byte_request, .busy, .invalid_request_flag,
    .host_bus_parity_error_flag, .cmd_block, .cmd_valid, .exec_has_data, .exec_to_host,
    .exec_sector_len, .exec_sector_count, .exec_attempt_fail(1'b0), .exec_fatal_error,
    .exec_channel_error(1'b0), .exec_err_code, .exec_unit_wp(1'b0), .to_host_valid,
    .to_host_ready, .to_host_data, .from_host_valid, .from_host_ready, .from_host_data,
    .retry_correctable, .failed_lba);

  // Engine stream with random stalls; the queue is the expected byte order
  always @(posedge mclk) begin
    from_host_ready <= 1'($random(seed));
    if (to_host_valid && to_host_ready) begin
      q.push_back(to_host_data);
      left--;
      to_host_data <= 8'($random(seed));
    end
    if (!to_host_valid || to_host_ready) begin
      to_host_valid <= left > 0 && ($random(seed) & 3) != 0;
    end
    if (from_host_valid && from_host_ready) begin
      check(from_host_data, w.pop_front());
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic await(input logic [5:0] mask, input logic [5:0] val);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while ((fl & mask) !== val && n < 3000);
    if (n >= 3000) begin
      failures++;
      $display("wrong value at %0t: flags stuck at %b", $time, fl);
    end
  endtask

  task automatic bus(input int kind, input logic [7:0] d);
    hm.start(kind, d);
    repeat (5) @(posedge mclk);
    hm.stop();
  endtask

  // Acknowledge and compare the response byte while the ack cycle stands
  task automatic ack_check(input logic [3:0] st);
    hm.start(3, 8'h00);
    repeat (5) @(posedge mclk);
    #1;
    check(host_rdata, {st, CTRL_ADDR_DEFAULT});
    hm.stop();
  endtask

  task automatic run_cmd(input bit data, input bit to_host, input bit fatal,
    input logic [6:0] code);
    logic [47:0] blk;
    blk = 48'({$random(seed), $random(seed)});
    blk[39] = 1'b0;
    @(posedge mclk);
    exec_has_data <= data;
    exec_to_host <= to_host;
    exec_err_code <= {1'b0, code};
    left = (data && to_host && !fatal) ? SECTOR_SMALL : 0;
    bus(0, 8'h00);
    await(6'b111001, 6'b101001);
    ack_check(4'h2);
    for (int i = 0; i < CMD_BYTES; i++) begin
      bus(1, blk[47 - 8 * i -: 8]);
      if (i < CMD_BYTES - 1) check(byte_request, 1'b1);
    end
    check(cmd_block, blk);
    if (data) begin
      await(6'b011001, {1'b0, to_host, 4'b0001});
      if (fatal) begin
        @(posedge mclk);
        exec_fatal_error <= 1'b1;
        @(posedge mclk);
        exec_fatal_error <= 1'b0;
      end else begin
        ack_check({to_host, 3'h0});
        // Host is slower than the stream, so the buffer fills and refuses meanwhile
        repeat (SECTOR_SMALL) begin
          await(6'b000010, 6'b000010);
          if (to_host) begin
            // Byte lands three edges after the strobe; the last one gives way to status
            hm.start(2, 8'h00);
            repeat (3) @(posedge mclk);
            #1;
            check(host_rdata, q.pop_front());
            repeat (2) @(posedge mclk);
            hm.stop();
          end else begin
            w.push_back(8'($random(seed)));
            bus(1, w[$]);
          end
        end
      end
    end
    await(6'b111111, 6'b111011);
    check(host_rdata, {1'b0, blk[38:37], 3'h0, fatal, 1'b0});
    check(failed_lba, fatal ? {3'h0, blk[36:16]} : 24'h0);
    check(w.size() + q.size(), 0);
    ack_check(4'ha);
    bus(2, 8'h00);
    await(6'b111111, 6'b111111);
    check(host_rdata, fatal ? {1'b1, code} : 8'h00);
    ack_check(4'hb);
    bus(2, 8'h00);
    check({fl, invalid_request_flag}, 7'h00);
  endtask

  task automatic give_verdict;
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check({fl, invalid_request_flag, to_host_ready}, 8'h00);
    repeat (5000) @(posedge mclk);
    bus(1, 8'h11);
    check({invalid_request_flag, host_irq}, 2'b11);
    ack_check(4'h4);
    check(invalid_request_flag, 1'b0);
    run_cmd(1'b0, 1'b1, 1'b0, 7'h00);
    run_cmd(1'b1, 1'b1, 1'b0, 7'h00);
    run_cmd(1'b1, 1'b0, 1'b0, 7'h00);
    run_cmd(1'b1, 1'b1, 1'b1, 7'($random(seed)));
    give_verdict();
  end
endmodule

bind storage_ctrl_host_command_sequencer seq_checker chk (.mclk, .rst, .host_select,
  .host_write, .host_irq, .direction, .cmd_data, .message_phase_flag, .byte_request, .busy,
  .invalid_request_flag, .cmd_valid, .to_host_ready, .from_host_valid);
`default_nettype wire
